// [qrs_map.svh]
// Purpose: constants of the quasi-resonant switch timing core
// Assumes: 250 MHz core clock
// Notes: times in their own unit; cycle counts derive from them
`ifndef QRS_MAP_SVH
`define QRS_MAP_SVH
`define QRS_MCLK_MHZ 250
`define QRS_T_PERIOD_MS 48
`define QRS_T_OVP_US 100
`define QRS_T_SW_NS 190
`define QRS_T_LEB_NS 200
`define QRS_T_RS_SHORT_NS 2000
`define QRS_T_RS_LONG_NS 10000
`define QRS_F_MIN_KHZ 20
`define QRS_T_MAXON_US 25
`define QRS_VALLEY_MIN 3'h1
`define QRS_VALLEY_MAX 3'h7
`define QRS_ZC_MAX 3'h7
// register byte offsets
`define QRS_OFS_CTRL 8'h00
`define QRS_OFS_STATUS 8'h04
`define QRS_OFS_THRESH 8'h08
`define QRS_OFS_FOLD 8'h0C
// control fields
`define QRS_CTRL_EN 0
`define QRS_CTRL_CLR 1
// status fields
`define QRS_ST_VALLEY 2:0
`define QRS_ST_ZC 6:4
`define QRS_ST_GATE 8
`define QRS_ST_OVP 9
`define QRS_ST_SW 10
// reset values
`define QRS_THRESH_RST 32'h0000_0000
`define QRS_FOLD_RST 32'h0000_FF00
`endif

// [qrs_pkg.sv]
// Purpose: shared types of the quasi-resonant switch timing core
// Assumes: nothing beyond the map header
// Notes: comparator levels travel as one packed struct
package qrs_pkg;
    typedef struct packed {
        logic fb_up;
        logic fb_down;
        logic fb_reset;
        logic sense_fb;
        logic cur_lim;
        logic short_wind;
        logic ovp;
        logic zc_cross;
        logic zc_rs_low;
        logic burst_exit;
    } qrs_cmp_s;

    typedef enum logic [2:0] {
        QRS_RING = 3'h1,
        QRS_WAIT = 3'h2,
        QRS_ON = 3'h4
    } qrs_gate_e;
endpackage : qrs_pkg

// [qrs_switch_timing.sv]
// Purpose: valley select, zero-crossing count and gate timing of a
//          quasi-resonant flyback controller, with an APB register port
// Assumes: comparator levels arrive as a packed struct, synchronised here
// Notes: long counts are parameters so simulation can shorten them
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "qrs_map.svh"

// Behaviour
// [R1] compare feedback thresholds every 48 ms period
// [R2] always below up threshold: count up
// [R3] between up and down thresholds: hold
// [R4] above down threshold: count down
// [R5] above reset threshold: force valley to 1
// [R6] valley select stays within 1 to 7
// [R7] valley select starts at 1
// [R8] line level picks up/down thresholds
// [R9] count valley crossings after turn-off, max 7
// [R10] clear crossing count at gate rise
// [R11] persistent off-time overvoltage latches off
// [R12] ring suppression length from zc level
// [R13] no turn-on during ring suppression
// [R14] turn on when crossings reach valley select
// [R15] maximum off-time forces turn-on
// [R16] sense above feedback turns gate off
// [R17] blanking after turn-on sets minimum on-time
// [R18] maximum on-time forces turn-off
// [R19] current limit turns gate off after blanking
// [R20] short-winding needs spike-filtered persistence to latch
// [R21] foldback lowers sense limit by excess current
// [R22] leaving burst forces valley select to 1
// [R23] synchronise comparators, record per-period threshold flags
module qrs_switch_timing #(
    parameter int unsigned PERIOD_CYC = `QRS_T_PERIOD_MS * `QRS_MCLK_MHZ * 1000,
    parameter int unsigned OVP_CYC = `QRS_T_OVP_US * `QRS_MCLK_MHZ,
    parameter int unsigned MAXOFF_CYC = (1000 * `QRS_MCLK_MHZ) / `QRS_F_MIN_KHZ,
    parameter int unsigned MAXON_CYC = `QRS_T_MAXON_US * `QRS_MCLK_MHZ,
    parameter int unsigned RS_SHORT_CYC = (`QRS_T_RS_SHORT_NS * `QRS_MCLK_MHZ + 999) / 1000,
    parameter int unsigned RS_LONG_CYC = (`QRS_T_RS_LONG_NS * `QRS_MCLK_MHZ + 999) / 1000,
    parameter int unsigned LEB_CYC = (`QRS_T_LEB_NS * `QRS_MCLK_MHZ + 999) / 1000,
    parameter int unsigned SW_CYC = (`QRS_T_SW_NS * `QRS_MCLK_MHZ + 999) / 1000
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire qrs_pkg::qrs_cmp_s i_cmp,
    input wire logic i_high_line,
    input wire logic [7:0] i_zc_current,
    output logic o_gate_drive_output,
    output logic [7:0] o_count_up_threshold,
    output logic [7:0] o_count_down_threshold,
    output logic [7:0] o_cs_limit,
    output logic o_latched
);

    // ----------------------------------------------------------------
    // comparator synchronisers
    // ----------------------------------------------------------------
    qrs_pkg::qrs_cmp_s cmp_meta_reg;
    qrs_pkg::qrs_cmp_s cmp_reg;
    logic zc_cross_d_reg;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_meta_reg <= '0;
            cmp_reg <= '0;
            zc_cross_d_reg <= 1'b0;
        end else begin
            cmp_meta_reg <= i_cmp; // [R23]
            cmp_reg <= cmp_meta_reg;
            zc_cross_d_reg <= cmp_reg.zc_cross;
        end
    end

    // ----------------------------------------------------------------
    // APB registers
    // ----------------------------------------------------------------
    logic en_reg;
    logic [31:0] thresh_reg;
    logic [31:0] fold_reg;
    logic wr_ctrl;
    logic clr_pulse;
    logic acc;

    assign acc = i_psel && i_penable && o_pready;
    assign wr_ctrl = acc && i_pwrite && (i_paddr == `QRS_OFS_CTRL);
    assign clr_pulse = wr_ctrl && i_pwdata[`QRS_CTRL_CLR];

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_reg <= 1'b0;
            thresh_reg <= `QRS_THRESH_RST;
            fold_reg <= `QRS_FOLD_RST;
        end else if (acc && i_pwrite) begin
            if (i_paddr == `QRS_OFS_CTRL) begin
                en_reg <= i_pwdata[`QRS_CTRL_EN];
            end
            if (i_paddr == `QRS_OFS_THRESH) begin
                thresh_reg <= i_pwdata;
            end
            if (i_paddr == `QRS_OFS_FOLD) begin
                fold_reg <= i_pwdata;
            end
        end
    end

    // answer one cycle after setup: pready high in the first access cycle
    logic [31:0] rdata_next;
    logic [2:0] valley_reg;
    logic [2:0] zc_reg;
    logic ovp_lat_reg;
    logic sw_lat_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (i_paddr)
            `QRS_OFS_CTRL: rdata_next[`QRS_CTRL_EN] = en_reg;
            `QRS_OFS_STATUS: begin
                rdata_next[`QRS_ST_VALLEY] = valley_reg;
                rdata_next[`QRS_ST_ZC] = zc_reg;
                rdata_next[`QRS_ST_GATE] = o_gate_drive_output;
                rdata_next[`QRS_ST_OVP] = ovp_lat_reg;
                rdata_next[`QRS_ST_SW] = sw_lat_reg;
            end
            `QRS_OFS_THRESH: rdata_next = thresh_reg;
            `QRS_OFS_FOLD: rdata_next = fold_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_prdata <= rdata_next;
            o_pslverr <= i_psel && !i_penable && (i_paddr != `QRS_OFS_CTRL)
                && (i_paddr != `QRS_OFS_STATUS) && (i_paddr != `QRS_OFS_THRESH)
                && (i_paddr != `QRS_OFS_FOLD);
        end
    end

    // ----------------------------------------------------------------
    // threshold selection and foldback
    // ----------------------------------------------------------------
    logic [7:0] excess;
    assign excess = i_zc_current - fold_reg[7:0];

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_count_up_threshold <= 8'h00;
            o_count_down_threshold <= 8'h00;
            o_cs_limit <= 8'h00;
        end else begin
            // line-dependent pair keeps hysteresis clear of foldback
            o_count_up_threshold <= i_high_line ? thresh_reg[23:16]
                : thresh_reg[7:0]; // [R8]
            o_count_down_threshold <= i_high_line ? thresh_reg[31:24]
                : thresh_reg[15:8]; // [R8]
            if (i_zc_current <= fold_reg[7:0]) begin
                o_cs_limit <= fold_reg[15:8];
            end else if (excess >= fold_reg[15:8]) begin
                o_cs_limit <= 8'h00;
            end else begin
                o_cs_limit <= fold_reg[15:8] - excess; // [R21]
            end
        end
    end

    // ----------------------------------------------------------------
    // valley select over the evaluation period
    // ----------------------------------------------------------------
    logic [31:0] per_cnt_reg;
    logic per_end;
    logic seen_up_reg;
    logic seen_down_reg;
    logic seen_rst_reg;

    assign per_end = (per_cnt_reg == PERIOD_CYC - 1);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            per_cnt_reg <= 32'h0000_0000;
        end else begin
            per_cnt_reg <= per_end ? 32'h0000_0000 : per_cnt_reg + 32'h0000_0001; // [R1]
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seen_up_reg <= 1'b0;
            seen_down_reg <= 1'b0;
            seen_rst_reg <= 1'b0;
        end else if (per_end) begin
            seen_up_reg <= cmp_reg.fb_up; // [R23]
            seen_down_reg <= cmp_reg.fb_down;
            seen_rst_reg <= cmp_reg.fb_reset;
        end else begin
            seen_up_reg <= seen_up_reg | cmp_reg.fb_up;
            seen_down_reg <= seen_down_reg | cmp_reg.fb_down;
            seen_rst_reg <= seen_rst_reg | cmp_reg.fb_reset;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            valley_reg <= `QRS_VALLEY_MIN; // [R7]
        end else if (cmp_reg.burst_exit) begin
            valley_reg <= `QRS_VALLEY_MIN; // [R22]
        end else if (per_end) begin
            if (seen_rst_reg) begin
                valley_reg <= `QRS_VALLEY_MIN; // [R5]
            end else if (seen_down_reg) begin
                if (valley_reg != `QRS_VALLEY_MIN) begin
                    valley_reg <= valley_reg - 3'h1; // [R4] [R6]
                end
            end else if (!seen_up_reg && valley_reg != `QRS_VALLEY_MAX) begin
                valley_reg <= valley_reg + 3'h1; // [R2] [R6]
            end
            // otherwise hold [R3]
        end
    end

    // ----------------------------------------------------------------
    // gate state machine
    // ----------------------------------------------------------------
    qrs_pkg::qrs_gate_e st_reg;
    logic [31:0] off_cnt_reg;
    logic [31:0] on_cnt_reg;
    logic rs_long_reg;
    logic rs_done;
    logic turn_on;
    logic turn_off;
    logic blocked;

    assign blocked = !en_reg || o_latched;
    assign rs_done = rs_long_reg ? (off_cnt_reg >= RS_LONG_CYC)
        : (off_cnt_reg >= RS_SHORT_CYC);
    assign turn_on = (st_reg == qrs_pkg::QRS_WAIT) && !blocked
        && ((zc_reg >= valley_reg) || (off_cnt_reg >= MAXOFF_CYC)); // [R14] [R15]
    // blanking masks the sense and limit comparators only
    assign turn_off = (st_reg == qrs_pkg::QRS_ON) && (blocked
        || (on_cnt_reg >= MAXON_CYC) // [R18]
        || ((on_cnt_reg >= LEB_CYC) && (cmp_reg.sense_fb || cmp_reg.cur_lim))); // [R16] [R17] [R19]

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= qrs_pkg::QRS_RING;
            o_gate_drive_output <= 1'b0;
            rs_long_reg <= 1'b0;
        end else begin
            case (st_reg)
                qrs_pkg::QRS_RING: begin
                    if (rs_done) begin
                        st_reg <= qrs_pkg::QRS_WAIT; // [R13]
                    end
                end
                qrs_pkg::QRS_WAIT: begin
                    if (turn_on) begin
                        st_reg <= qrs_pkg::QRS_ON;
                        o_gate_drive_output <= 1'b1;
                    end
                end
                qrs_pkg::QRS_ON: begin
                    if (turn_off) begin
                        st_reg <= qrs_pkg::QRS_RING;
                        o_gate_drive_output <= 1'b0;
                        rs_long_reg <= cmp_reg.zc_rs_low; // [R12]
                    end
                end
                default: begin
                    st_reg <= qrs_pkg::QRS_RING;
                    o_gate_drive_output <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            off_cnt_reg <= 32'h0000_0000;
            on_cnt_reg <= 32'h0000_0000;
        end else begin
            if (st_reg == qrs_pkg::QRS_ON) begin
                off_cnt_reg <= 32'h0000_0000;
            end else if (off_cnt_reg != MAXOFF_CYC) begin
                off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
            end
            if (st_reg != qrs_pkg::QRS_ON || turn_off) begin
                on_cnt_reg <= 32'h0000_0000;
            end else if (on_cnt_reg != MAXON_CYC) begin
                on_cnt_reg <= on_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // zero-crossing counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            zc_reg <= 3'h0;
        end else if (turn_on) begin
            zc_reg <= 3'h0; // [R10]
        end else if (st_reg != qrs_pkg::QRS_ON && zc_cross_d_reg && !cmp_reg.zc_cross
            && zc_reg != `QRS_ZC_MAX) begin
            zc_reg <= zc_reg + 3'h1; // [R9]
        end
    end

    // ----------------------------------------------------------------
    // latch-off protections
    // ----------------------------------------------------------------
    logic [31:0] ovp_cnt_reg;
    logic [31:0] sw_cnt_reg;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ovp_cnt_reg <= 32'h0000_0000;
            sw_cnt_reg <= 32'h0000_0000;
        end else begin
            if (!cmp_reg.ovp || st_reg == qrs_pkg::QRS_ON) begin
                ovp_cnt_reg <= 32'h0000_0000;
            end else if (ovp_cnt_reg != OVP_CYC) begin
                ovp_cnt_reg <= ovp_cnt_reg + 32'h0000_0001; // [R11]
            end
            // spike filter: any dropout restarts the count
            if (!cmp_reg.short_wind || st_reg != qrs_pkg::QRS_ON) begin
                sw_cnt_reg <= 32'h0000_0000;
            end else if (sw_cnt_reg != SW_CYC) begin
                sw_cnt_reg <= sw_cnt_reg + 32'h0000_0001; // [R20]
            end
        end
    end

    // set beats a software clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ovp_lat_reg <= 1'b0;
            sw_lat_reg <= 1'b0;
            o_latched <= 1'b0;
        end else begin
            ovp_lat_reg <= (ovp_cnt_reg == OVP_CYC) || (ovp_lat_reg && !clr_pulse); // [R11]
            sw_lat_reg <= (sw_cnt_reg == SW_CYC) || (sw_lat_reg && !clr_pulse); // [R20]
            o_latched <= (ovp_cnt_reg == OVP_CYC) || (sw_cnt_reg == SW_CYC)
                || ((ovp_lat_reg || sw_lat_reg) && !clr_pulse);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence per_quiet_s;
        per_end && !seen_up_reg && !seen_down_reg && !seen_rst_reg;
    endsequence
    sequence ready_to_fire_s;
        st_reg == qrs_pkg::QRS_WAIT && !blocked && zc_reg >= valley_reg;
    endsequence

    valley_range_a: assert property (valley_reg >= `QRS_VALLEY_MIN) // [R6]
        else $error("valley select left its range");
    count_up_a: assert property (per_quiet_s ##0 (!cmp_reg.burst_exit && valley_reg != `QRS_VALLEY_MAX)
        |=> valley_reg == $past(valley_reg) + 3'h1) // [R2]
        else $error("valley select did not count up");
    hold_value_a: assert property (per_end && seen_up_reg && !seen_down_reg && !seen_rst_reg
        && !cmp_reg.burst_exit |=> $stable(valley_reg)) // [R3]
        else $error("valley select changed on hold");
    reset_force_a: assert property (per_end && seen_rst_reg |=> valley_reg == `QRS_VALLEY_MIN) // [R5]
        else $error("valley select not forced to one");
    burst_exit_a: assert property (cmp_reg.burst_exit |=> valley_reg == `QRS_VALLEY_MIN) // [R22]
        else $error("burst exit did not force valley one");
    zc_clear_a: assert property ($rose(o_gate_drive_output) |-> zc_reg == 3'h0) // [R10]
        else $error("crossing count not cleared at turn-on");
    ring_hold_a: assert property ($rose(o_gate_drive_output) |-> $past(rs_done)) // [R13]
        else $error("gate rose inside ring suppression");
    valley_on_a: assert property (ready_to_fire_s |=> o_gate_drive_output ##1 zc_reg == 3'h0) // [R14]
        else $error("gate missed a valley turn-on");
    max_off_a: assert property (st_reg == qrs_pkg::QRS_WAIT && !blocked
        && off_cnt_reg >= MAXOFF_CYC |=> o_gate_drive_output) // [R15]
        else $error("maximum off-time did not turn on");
    min_on_a: assert property ($fell(o_gate_drive_output) && $past(!blocked)
        && $past(on_cnt_reg) < LEB_CYC |-> 1'b0) // [R17]
        else $error("gate dropped inside blanking");
    max_on_a: assert property (o_gate_drive_output && on_cnt_reg >= MAXON_CYC
        |=> !o_gate_drive_output) // [R18]
        else $error("maximum on-time not enforced");
    sw_latch_a: assert property ($rose(sw_lat_reg) |-> $past(sw_cnt_reg) == SW_CYC) // [R20]
        else $error("short-winding latched without filter time");

endmodule : qrs_switch_timing

// [qrs_cmp_model.sv]
// Purpose: behavioural sense comparators and valley ringing seen by the core
// Assumes: knobs set by the bench; counts in core clock cycles
// Notes: zc pin is clamped low while the switch conducts
`timescale 1ns/1ps
module qrs_cmp_model (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_gate,
    input wire logic [7:0] i_on_t,
    input wire logic i_use_lim,
    input wire logic i_ring,
    output logic o_sense_fb,
    output logic o_cur_lim,
    output logic o_zc_cross
);
    // ----------------------------------------
    // phase timer
    // ----------------------------------------
    logic [7:0] cnt_reg;
    logic gate_reg;
    logic trip;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= 8'h00;
            gate_reg <= 1'b0;
        end else begin
            gate_reg <= i_gate;
            if (i_gate != gate_reg) begin
                cnt_reg <= 8'h00;
            end else if (cnt_reg != 8'hFF) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
    // ----------------------------------------
    // comparator levels
    // ----------------------------------------
    // on-time 8'hFF: sense ramp never reaches feedback, so only max on-time, a latch-off or disable ends it
    // gate_reg gating: the count left over from the last phase must not leak across a gate edge
    assign trip = i_gate && gate_reg && i_on_t != 8'hFF && cnt_reg >= i_on_t;
    assign o_sense_fb = trip && !i_use_lim;
    assign o_cur_lim = trip && i_use_lim;
    // one falling crossing every 8 off cycles, the first at cycle 8
    assign o_zc_cross = !i_gate && !gate_reg && i_ring && cnt_reg[2];
endmodule : qrs_cmp_model

// [qrs_switch_timing_tb.sv]
// Purpose: self-checking bench of the switch timing core
// Assumes: shortened counts; comparator model drives sense and ringing
// Notes: register values drawn from an xorshift seeded at 46
`timescale 1ns/1ps
`include "qrs_map.svh"
module qrs_switch_timing_tb;
    localparam int PER = 64, OVP = 20, MOFF = 200, MON = 100;
    localparam int RSS = 10, RSL = 30, LEB = 5, SWB = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, hl = 1'b0, err;
    logic [7:0] paddr = 8'h00, izc = 8'h00, on_t = 8'h14, up_thr, dn_thr, cs_lim;
    logic [31:0] pwdata = 32'h0, prdata, rd, wr, r2, seed = 32'h2E;
    logic pready, pslverr, gate, latched, gq = 1'b0, m_sense, m_lim, m_zc;
    logic fu = 1'b0, fd = 1'b0, fr = 1'b0, sw = 1'b0, ovp = 1'b0;
    logic rsl = 1'b0, bx = 1'b0, lim = 1'b0, ring = 1'b1;
    qrs_pkg::qrs_cmp_s cmp;
    int mismatches = 0, comparisons = 0, cnt = 0, on_len = 0, off_len = 0, pulses = 0;
    assign cmp = {fu, fd, fr, m_sense, m_lim, sw, ovp, m_zc, rsl, bx};
    always #2 clk = ~clk;

    qrs_switch_timing #(.PERIOD_CYC(PER), .OVP_CYC(OVP), .MAXOFF_CYC(MOFF), .MAXON_CYC(MON),
        .RS_SHORT_CYC(RSS), .RS_LONG_CYC(RSL), .LEB_CYC(LEB), .SW_CYC(SWB)) u_qrs_switch_timing (
        .i_mclk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_cmp(cmp), .i_high_line(hl), .i_zc_current(izc),
        .o_gate_drive_output(gate), .o_count_up_threshold(up_thr),
        .o_count_down_threshold(dn_thr), .o_cs_limit(cs_lim), .o_latched(latched));
    qrs_cmp_model u_qrs_cmp_model (.i_mclk(clk), .i_rst_b(rst_b), .i_gate(gate),
        .i_on_t(on_t), .i_use_lim(lim), .i_ring(ring), .o_sense_fb(m_sense),
        .o_cur_lim(m_lim), .o_zc_cross(m_zc));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] fold_exp(input logic [31:0] f, input logic [7:0] i);
        if (i <= f[7:0]) return f[15:8];
        if (i - f[7:0] >= f[15:8]) return 8'h00;
        return f[15:8] - (i - f[7:0]);
    endfunction : fold_exp

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic hang(input int n, input int lim_n);
        if (n >= lim_n) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : hang

    // call just after a rising edge; request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        hang(n, 40);
    endtask : apb

    task automatic wait_pulses(input int n);
        int t, p;
        p = pulses + n;
        t = 0;
        while (pulses < p && t < 2000) begin
            @(posedge clk);
            t++;
        end
        hang(t, 2000);
    endtask : wait_pulses

    task automatic meas(input logic [7:0] t, input logic l, r, s, o, input int lo, hi);
        int v;
        on_t <= t;
        lim <= l;
        ring <= r;
        rsl <= s;
        wait_pulses(3);
        v = o ? on_len : off_len;
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : meas

    task automatic settle(input logic u, d, input int n, input logic [2:0] e);
        fu <= u;
        fd <= d;
        repeat (n * PER) @(posedge clk);
        apb(1'b0, `QRS_OFS_STATUS, 32'h0);
        check({29'h0, rd[`QRS_ST_VALLEY]}, {29'h0, e});
    endtask : settle

    // gate phase lengths in cycles, recorded at each edge of the gate
    always @(posedge clk) begin
        gq <= gate;
        if (gate !== gq) begin
            cnt <= 1;
            if (gq) begin
                on_len <= cnt;
            end else begin
                off_len <= cnt;
                pulses <= pulses + 1;
            end
        end else begin
            cnt <= cnt + 1;
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        settle(1'b0, 1'b0, 0, 3'h1);
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b0, `QRS_OFS_FOLD, 32'h0);
        check(rd, `QRS_FOLD_RST);
        wr = rnd();
        apb(1'b1, `QRS_OFS_THRESH, wr);
        for (int h = 0; h < 2; h++) begin
            hl <= h[0];
            repeat (3) @(posedge clk);
            check({16'h0, up_thr, dn_thr}, {16'h0, h ? {wr[23:16], wr[31:24]} : {wr[7:0], wr[15:8]}});
        end
        for (int k = 0; k < 4; k++) begin
            wr = rnd() & 32'h0000_FFFF;
            r2 = rnd();
            izc <= r2[7:0];
            apb(1'b1, `QRS_OFS_FOLD, wr);
            repeat (3) @(posedge clk);
            check({24'h0, cs_lim}, {24'h0, fold_exp(wr, izc)});
        end
        apb(1'b1, `QRS_OFS_CTRL, 32'h1);
        settle(1'b0, 1'b0, 8, 3'h7);
        meas(8'h14, 1'b0, 1'b1, 1'b0, 1'b0, 56, 66);
        meas(8'h14, 1'b0, 1'b1, 1'b0, 1'b1, 20, 27);
        settle(1'b1, 1'b0, 3, 3'h7);
        bx <= 1'b1;
        repeat (2) @(posedge clk);
        bx <= 1'b0;
        repeat (6) @(posedge clk);
        settle(1'b1, 1'b0, 0, 3'h1);
        settle(1'b0, 1'b0, 8, 3'h7);
        fr <= 1'b1;
        repeat (3) @(posedge clk);
        fr <= 1'b0;
        settle(1'b1, 1'b0, 2, 3'h1);
        meas(8'h14, 1'b0, 1'b1, 1'b0, 1'b0, RSS, RSS + 10);
        meas(8'h14, 1'b0, 1'b1, 1'b1, 1'b0, RSL, RSL + 10);
        meas(8'h14, 1'b0, 1'b0, 1'b0, 1'b0, MOFF, MOFF + 4);
        meas(8'hFF, 1'b0, 1'b1, 1'b0, 1'b1, MON, MON + 3);
        meas(8'h00, 1'b0, 1'b1, 1'b0, 1'b1, LEB, LEB + 5);
        meas(8'h00, 1'b1, 1'b1, 1'b0, 1'b1, LEB, LEB + 5);
        settle(1'b0, 1'b0, 8, 3'h7);
        settle(1'b1, 1'b1, 8, 3'h1);
        // disabled core keeps the switch off for the overvoltage watch
        apb(1'b1, `QRS_OFS_CTRL, 32'h0);
        repeat (MON + 5) @(posedge clk);
        ovp <= 1'b1;
        repeat (OVP / 2) @(posedge clk);
        ovp <= 1'b0;
        repeat (8) @(posedge clk);
        check({31'h0, latched}, 32'h0);
        ovp <= 1'b1;
        repeat (OVP + 6) @(posedge clk);
        ovp <= 1'b0;
        check({31'h0, latched}, 32'h1);
        apb(1'b0, `QRS_OFS_STATUS, 32'h0);
        check({31'h0, rd[`QRS_ST_OVP]}, 32'h1);
        on_t <= 8'hFF;
        apb(1'b1, `QRS_OFS_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        check({31'h0, latched}, 32'h0);
        wait_pulses(1);
        sw <= 1'b1;
        repeat (2) @(posedge clk);
        sw <= 1'b0;
        repeat (8) @(posedge clk);
        check({31'h0, latched}, 32'h0);
        sw <= 1'b1;
        repeat (SWB + 6) @(posedge clk);
        sw <= 1'b0;
        check({31'h0, latched}, 32'h1);
        tally_and_finish();
    end
endmodule : qrs_switch_timing_tb
